// ===== logic/lift_safety_contact_monitor.sv
// Purpose: Drives the three safety actuator contacts of the lift safety circuit
// Assumes: Car state arrives each cycle; non-volatile store answers after reset
// Notes:   Contact outputs are high when the contact is closed

`timescale 1ns/1ps

// Contract
// - Final over-speed opens all three contacts
// - Latched trip kept in non-volatile storage
// - Second contact closed when bridging or doors closed
// - Levelling bridging: zone, below 0.8 m/s, enabled
// - Re-levelling bridging: zone, below 0.3 m/s, enabled
// - Door open without bridging opens second contact
// - Teach mode above 0.63 m/s opens first
// - Teach trip clears after 10 s standstill
// - Inspection without direction opens first and second
// - Reset is three short presses, short gaps
// - Valid reset clears stored error, closes contacts
// - Final over-speed released only by manual reset
// - Door zone is flush position plus/minus size
module lift_safety_contact_monitor #(
   parameter int NUM_FLOORS        = 16,
   parameter int STANDSTILL_CYCLES = lift_safety_pkg::STANDSTILL_CYCLES,
   parameter int PRESS_MAX_CYCLES  = lift_safety_pkg::PRESS_MAX_CYCLES,
   parameter int GAP_MAX_CYCLES    = lift_safety_pkg::GAP_MAX_CYCLES
) (
   input  wire logic                              CLK,
   input  wire logic                              RST,
   input  wire lift_safety_pkg::car_state_t        CAR,
   input  wire lift_safety_pkg::mode_t             MODE,
   input  wire logic [lift_safety_pkg::SPEED_W-1:0] NOMINAL_SPEED,
   input  wire lift_safety_pkg::zone_cfg_t         ZONE_CFG,
   input  wire logic                              FLUSH_WR,
   input  wire logic [$clog2(NUM_FLOORS)-1:0]     FLUSH_IDX,
   input  wire logic [lift_safety_pkg::POS_W-1:0] FLUSH_POS,
   input  wire logic [NUM_FLOORS-1:0]             LEVEL_BRIDGE_EN,
   input  wire logic [NUM_FLOORS-1:0]             RELEVEL_BRIDGE_EN,
   input  wire logic                              DOORS_CLOSED,
   input  wire logic                              DIRECTION_PRESSED,
   input  wire logic                              RESET_BUTTON,
   input  wire logic                              NV_READY,
   input  wire logic                              NV_TRIPPED,
   output logic                                   NV_STORE,
   output logic                                   NV_TRIPPED_OUT,
   output logic                                   FIRST_ACTUATOR_CONTACT,
   output logic                                   SECOND_ACTUATOR_CONTACT,
   output logic                                   SAFETY_GEAR_ACTUATOR_CONTACT,
   output logic                                   OVERSPEED_LATCHED,
   output logic                                   TEACH_TRIP,
   output logic                                   BRIDGING_ACTIVE
);
   import lift_safety_pkg::*;

   localparam int SS_W  = $clog2(STANDSTILL_CYCLES + 1);
   localparam int EXT_W = POS_W + 1;
   localparam int TRIP_W = SPEED_W + 8;

   // ------------------------------
   // Helpers
   // ------------------------------
   function automatic logic in_zone(
      input logic [POS_W-1:0]  pos,
      input logic [POS_W-1:0]  flush,
      input logic [ZONE_W-1:0] size
   );
      logic [EXT_W-1:0] p;
      logic [EXT_W-1:0] f;
      logic [EXT_W-1:0] s;
      p = {1'b0, pos};
      f = {1'b0, flush};
      s = EXT_W'(size);
      // Compare without subtracting so a zone near zero cannot wrap
      in_zone = (p + s >= f) && (p <= f + s);
   endfunction : in_zone

   typedef enum logic {
      ST_RESTORE,
      ST_RUN
   } run_state_t;

   // ------------------------------
   // State
   // ------------------------------
   run_state_t               state_reg;
   run_state_t               state_next;
   logic [POS_W-1:0]         flush_mem [NUM_FLOORS];
   logic                     overspeed_reg;
   logic                     overspeed_next;
   logic                     teach_trip_reg;
   logic                     teach_trip_next;
   logic [SS_W-1:0]          still_cnt_reg;
   logic [SS_W-1:0]          still_cnt_next;
   logic                     nv_store_reg;
   logic                     first_reg;
   logic                     second_reg;
   logic                     gear_reg;
   logic                     bridging_reg;
   logic [NUM_FLOORS-1:0]    level_hit;
   logic [NUM_FLOORS-1:0]    relevel_hit;
   logic                     manual_reset;

   // ------------------------------
   // Floor flush table
   // ------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         for (int i = 0; i < NUM_FLOORS; i++)
         begin
            flush_mem[i] <= '0;
         end
      end
      else if (FLUSH_WR)
      begin
         flush_mem[FLUSH_IDX] <= FLUSH_POS;
      end
   end

   // ------------------------------
   // Door zones per floor
   // ------------------------------
   generate
      for (genvar g = 0; g < NUM_FLOORS; g++)
      begin : g_floor
         assign level_hit[g]   = LEVEL_BRIDGE_EN[g] &&
                                 in_zone(CAR.position, flush_mem[g],
                                         ZONE_CFG.level_size);
         assign relevel_hit[g] = RELEVEL_BRIDGE_EN[g] &&
                                 in_zone(CAR.position, flush_mem[g],
                                         ZONE_CFG.relevel_size);
      end
   endgenerate

   wire logic level_ok   = (|level_hit) && (CAR.speed < LEVEL_SPEED_MAX);
   wire logic relevel_ok = (|relevel_hit) && (CAR.speed < RELEVEL_SPEED_MAX);
   wire logic bridging   = level_ok || relevel_ok;

   // ------------------------------
   // Speed decisions
   // ------------------------------
   wire logic [TRIP_W-1:0] nominal_ext = TRIP_W'(NOMINAL_SPEED);
   wire logic [TRIP_W-1:0] trip_speed  = nominal_ext +
                                         TRIP_W'(nominal_ext * TRIP_W'(TRIP_MARGIN_PCT)
                                                 / TRIP_W'(PCT_BASE));
   wire logic final_over  = TRIP_W'(CAR.speed) > trip_speed;
   wire logic teach_over  = (MODE == MODE_TEACH) && (CAR.speed > TEACH_SPEED_MAX);
   wire logic standstill  = CAR.speed == STANDSTILL_SPEED;
   wire logic still_done  = still_cnt_reg >= SS_W'(STANDSTILL_CYCLES);
   wire logic insp_hold   = (MODE == MODE_INSPECTION) && !DIRECTION_PRESSED;
   wire logic running     = state_reg == ST_RUN;

   // ------------------------------
   // Manual reset button
   // ------------------------------
   reset_press_detector #(
      .PRESS_MAX (PRESS_MAX_CYCLES),
      .GAP_MAX   (GAP_MAX_CYCLES)
   ) u_reset_press (
      .clk         (CLK),
      .rst         (RST),
      .button      (RESET_BUTTON),
      .reset_pulse (manual_reset)
   );

   // ------------------------------
   // Latched and timed trips
   // ------------------------------
   always_comb
   begin
      state_next      = state_reg;
      overspeed_next  = overspeed_reg;
      teach_trip_next = teach_trip_reg;
      still_cnt_next  = '0;
      case (state_reg)
         ST_RESTORE:
         begin
            if (NV_READY)
            begin
               overspeed_next = NV_TRIPPED;
               state_next     = ST_RUN;
            end
         end
         default:
         begin
            // A trip in the same cycle as the reset wins
            if (final_over)
            begin
               overspeed_next = 1'b1;
            end
            else if (manual_reset)
            begin
               overspeed_next = 1'b0;
            end
            if (teach_trip_reg && standstill && !still_done)
            begin
               still_cnt_next = still_cnt_reg + SS_W'(1);
            end
            if (teach_over)
            begin
               teach_trip_next = 1'b1;
            end
            else if (teach_trip_reg && still_done)
            begin
               teach_trip_next = 1'b0;
            end
         end
      endcase
   end

   // ------------------------------
   // Contact drive
   // ------------------------------
   wire logic first_next  = running && !overspeed_next && !teach_trip_next
                            && !insp_hold;
   wire logic second_next = running && !overspeed_next && !insp_hold
                            && (bridging || DOORS_CLOSED);
   wire logic gear_next   = running && !overspeed_next;
   wire logic nv_change   = running && (overspeed_next != overspeed_reg);

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state_reg      <= ST_RESTORE;
         overspeed_reg  <= 1'b1;
         teach_trip_reg <= 1'b0;
         still_cnt_reg  <= '0;
      end
      else
      begin
         state_reg      <= state_next;
         overspeed_reg  <= overspeed_next;
         teach_trip_reg <= teach_trip_next;
         still_cnt_reg  <= still_cnt_next;
      end
   end

   // Contacts stay open until the stored trip has been restored
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         first_reg    <= 1'b0;
         second_reg   <= 1'b0;
         gear_reg     <= 1'b0;
         bridging_reg <= 1'b0;
         nv_store_reg <= 1'b0;
      end
      else
      begin
         first_reg    <= first_next;
         second_reg   <= second_next;
         gear_reg     <= gear_next;
         bridging_reg <= running && bridging;
         nv_store_reg <= nv_change;
      end
   end

   assign FIRST_ACTUATOR_CONTACT       = first_reg;
   assign SECOND_ACTUATOR_CONTACT      = second_reg;
   assign SAFETY_GEAR_ACTUATOR_CONTACT = gear_reg;
   assign OVERSPEED_LATCHED            = overspeed_reg;
   assign NV_TRIPPED_OUT               = overspeed_reg;
   assign NV_STORE                     = nv_store_reg;
   assign TEACH_TRIP                   = teach_trip_reg;
   assign BRIDGING_ACTIVE              = bridging_reg;

endmodule : lift_safety_contact_monitor

// ===== shared/lift_safety_pkg.sv
// Purpose: Shared constants and types for the lift safety contact monitor
// Assumes: Speed in mm/s, position in mm, 20 MHz system clock
// Notes:   Contact outputs are high when the contact is closed

package lift_safety_pkg;

   // ------------------------------
   // Widths
   // ------------------------------
   localparam int POS_W   = 24;
   localparam int SPEED_W = 16;
   localparam int ZONE_W  = 16;

   // ------------------------------
   // Clock and times
   // ------------------------------
   localparam longint CLK_HZ        = 20000000;
   localparam longint MS_PER_S      = 1000;
   localparam longint STANDSTILL_MS = 10000;
   localparam longint PRESS_MAX_MS  = 500;
   localparam longint GAP_MAX_MS    = 500;
   localparam int STANDSTILL_CYCLES = int'(STANDSTILL_MS * CLK_HZ / MS_PER_S);
   localparam int PRESS_MAX_CYCLES  = int'(PRESS_MAX_MS * CLK_HZ / MS_PER_S);
   localparam int GAP_MAX_CYCLES    = int'(GAP_MAX_MS * CLK_HZ / MS_PER_S);

   // ------------------------------
   // Speed thresholds in mm/s
   // ------------------------------
   localparam logic [SPEED_W-1:0] LEVEL_SPEED_MAX   = 16'h0320;
   localparam logic [SPEED_W-1:0] RELEVEL_SPEED_MAX = 16'h012c;
   localparam logic [SPEED_W-1:0] TEACH_SPEED_MAX   = 16'h0276;
   localparam logic [SPEED_W-1:0] STANDSTILL_SPEED  = 16'h0000;

   // ------------------------------
   // Reset button sequence
   // ------------------------------
   localparam int          PRESS_CNT_W    = 2;
   localparam logic [1:0]  PRESSES_NEEDED = 2'h3;
   localparam logic [1:0]  PRESSES_NONE   = 2'h0;
   localparam logic [1:0]  PRESS_STEP     = 2'h1;

   // ------------------------------
   // Final tripping speed derivation
   // ------------------------------
   localparam int TRIP_MARGIN_PCT = 15;
   localparam int PCT_BASE        = 100;

   // ------------------------------
   // Types
   // ------------------------------
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_TEACH,
      MODE_INSPECTION
   } mode_t;

   typedef struct packed {
      logic [POS_W-1:0]   position;
      logic [SPEED_W-1:0] speed;
   } car_state_t;

   typedef struct packed {
      logic [ZONE_W-1:0] level_size;
      logic [ZONE_W-1:0] relevel_size;
   } zone_cfg_t;

endpackage : lift_safety_pkg

// ===== logic/reset_press_detector.sv
// Purpose: Recognises the triple short press of the manual reset button
// Assumes: Button input is synchronous and high while pressed
// Notes:   Emits a one-cycle pulse on a valid sequence

`timescale 1ns/1ps

module reset_press_detector #(
   parameter int PRESS_MAX = lift_safety_pkg::PRESS_MAX_CYCLES,
   parameter int GAP_MAX   = lift_safety_pkg::GAP_MAX_CYCLES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic button,
   output logic      reset_pulse
);
   import lift_safety_pkg::*;

   localparam int CNT_W = $clog2(PRESS_MAX + GAP_MAX + 2);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PRESSED,
      ST_GAP,
      ST_HELD_LONG
   } press_state_t;

   press_state_t             state_reg;
   press_state_t             state_next;
   logic [CNT_W-1:0]         timer_reg;
   logic [CNT_W-1:0]         timer_next;
   logic [PRESS_CNT_W-1:0]   presses_reg;
   logic [PRESS_CNT_W-1:0]   presses_next;
   logic                     pulse_reg;
   logic                     pulse_next;

   // The timer reads zero in the first cycle of a press or a gap
   wire logic press_too_long = timer_reg >= CNT_W'(PRESS_MAX - 1);
   wire logic gap_too_long   = timer_reg >= CNT_W'(GAP_MAX - 1);
   wire logic [PRESS_CNT_W-1:0] presses_inc = presses_reg + PRESS_STEP;

   // ------------------------------
   // Sequence tracking
   // ------------------------------
   always_comb
   begin
      state_next   = state_reg;
      timer_next   = timer_reg + CNT_W'(1);
      presses_next = presses_reg;
      pulse_next   = 1'b0;
      case (state_reg)
         ST_IDLE:
         begin
            timer_next = '0;
            if (button)
            begin
               state_next = ST_PRESSED;
            end
         end
         ST_PRESSED:
         begin
            if (press_too_long)
            begin
               state_next   = ST_HELD_LONG;
               presses_next = PRESSES_NONE;
            end
            else if (!button)
            begin
               timer_next = '0;
               if (presses_inc == PRESSES_NEEDED)
               begin
                  pulse_next   = 1'b1;
                  presses_next = PRESSES_NONE;
                  state_next   = ST_IDLE;
               end
               else
               begin
                  presses_next = presses_inc;
                  state_next   = ST_GAP;
               end
            end
         end
         ST_GAP:
         begin
            if (gap_too_long)
            begin
               timer_next   = '0;
               presses_next = PRESSES_NONE;
               state_next   = button ? ST_PRESSED : ST_IDLE;
            end
            else if (button)
            begin
               timer_next = '0;
               state_next = ST_PRESSED;
            end
         end
         default:
         begin
            timer_next = '0;
            if (!button)
            begin
               state_next = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         state_reg   <= ST_IDLE;
         timer_reg   <= '0;
         presses_reg <= PRESSES_NONE;
         pulse_reg   <= 1'b0;
      end
      else
      begin
         state_reg   <= state_next;
         timer_reg   <= timer_next;
         presses_reg <= presses_next;
         pulse_reg   <= pulse_next;
      end
   end

   assign reset_pulse = pulse_reg;

endmodule : reset_press_detector

// ===== verif/lift_safety_monitor.sv
// Purpose: Concurrent checks on the contact monitor ports
// Assumes: Closed contact reads high; one clock domain
// Notes:   Helper counters track restore, button release and standstill
`timescale 1ns/1ps
module lift_safety_monitor #(
   parameter int STANDSTILL_CYCLES = 50
) (
   input wire logic                            CLK,
   input wire logic                            RST,
   input wire lift_safety_pkg::car_state_t     CAR,
   input wire lift_safety_pkg::mode_t          MODE,
   input wire logic [lift_safety_pkg::SPEED_W-1:0] NOMINAL_SPEED,
   input wire logic                            DOORS_CLOSED,
   input wire logic                            DIRECTION_PRESSED,
   input wire logic                            RESET_BUTTON,
   input wire logic                            NV_READY,
   input wire logic                            NV_STORE,
   input wire logic                            FIRST_ACTUATOR_CONTACT,
   input wire logic                            SECOND_ACTUATOR_CONTACT,
   input wire logic                            SAFETY_GEAR_ACTUATOR_CONTACT,
   input wire logic                            OVERSPEED_LATCHED,
   input wire logic                            TEACH_TRIP,
   input wire logic                            BRIDGING_ACTIVE
);
   import lift_safety_pkg::*;
   logic        run_reg;
   logic [3:0]  rel_reg;
   int          still_reg;
   logic [16:0] trip_speed;
   assign trip_speed = 17'(NOMINAL_SPEED) + 17'(NOMINAL_SPEED * TRIP_MARGIN_PCT / PCT_BASE);
   // ------------------------------
   // Helper state
   // ------------------------------
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         run_reg   <= 1'b0;
         rel_reg   <= 4'h0;
         still_reg <= 0;
      end
      else
      begin
         run_reg   <= run_reg | NV_READY;
         rel_reg   <= RESET_BUTTON ? 4'h0 : (rel_reg == 4'hf ? rel_reg : rel_reg + 4'h1);
         still_reg <= (CAR.speed == STANDSTILL_SPEED) ? still_reg + 1 : 0;
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   sequence door_open_unbridged;
      !DOORS_CLOSED ##1 !BRIDGING_ACTIVE;
   endsequence
   sequence clear_path;
      run_reg && DOORS_CLOSED && MODE != MODE_INSPECTION && CAR.speed <= trip_speed
      ##1 !OVERSPEED_LATCHED;
   endsequence
   // ------------------------------
   // Assertions
   // ------------------------------
   AST_OVERSPEED_OPENS: assert property (CAR.speed > trip_speed |=>
      !FIRST_ACTUATOR_CONTACT && !SECOND_ACTUATOR_CONTACT && !SAFETY_GEAR_ACTUATOR_CONTACT)
      else $error("over-speed left a contact closed");
   AST_LATCH_HOLDS: assert property (run_reg && OVERSPEED_LATCHED && rel_reg > 4'h6
      |=> OVERSPEED_LATCHED) else $error("latch released without button");
   AST_NV_STORED: assert property ($past(run_reg) && $changed(OVERSPEED_LATCHED)
      |-> ##[0:1] NV_STORE) else $error("latch change not stored");
   AST_GEAR_LATCH: assert property (SAFETY_GEAR_ACTUATOR_CONTACT |-> !OVERSPEED_LATCHED)
      else $error("gear contact closed while latched");
   AST_DOOR_OPEN: assert property (door_open_unbridged |-> !SECOND_ACTUATOR_CONTACT)
      else $error("second contact closed with open door");
   AST_SECOND_CLOSED: assert property (clear_path |-> SECOND_ACTUATOR_CONTACT)
      else $error("second contact open with doors closed");
   AST_BRIDGE_SPEED: assert property (CAR.speed >= LEVEL_SPEED_MAX |=> !BRIDGING_ACTIVE)
      else $error("bridging at levelling speed limit");
   AST_TEACH_TRIP: assert property (run_reg && MODE == MODE_TEACH
      && CAR.speed > TEACH_SPEED_MAX |=> TEACH_TRIP && !FIRST_ACTUATOR_CONTACT)
      else $error("teach over-speed missed");
   AST_TEACH_FIRST: assert property (TEACH_TRIP |-> !FIRST_ACTUATOR_CONTACT)
      else $error("first contact closed during teach trip");
   AST_TEACH_HOLD: assert property (TEACH_TRIP && still_reg < STANDSTILL_CYCLES - 2
      |=> TEACH_TRIP) else $error("teach trip cleared early");
   AST_TEACH_CLEAR: assert property (still_reg > STANDSTILL_CYCLES + 2 |-> !TEACH_TRIP)
      else $error("teach trip not cleared at standstill");
   AST_INSPECT: assert property (run_reg && MODE == MODE_INSPECTION && !DIRECTION_PRESSED
      |=> !FIRST_ACTUATOR_CONTACT && !SECOND_ACTUATOR_CONTACT)
      else $error("inspection hold left a contact closed");
endmodule : lift_safety_monitor

// ===== verif/nv_store_model.sv
// Purpose: Behavioural non-volatile store for the over-speed trip
// Assumes: Content survives reset; ready rises a few cycles after reset
// Notes:   A fresh store holds no trip
`timescale 1ns/1ps
module nv_store_model #(
   parameter int READY_DELAY = 4
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic store,
   input  wire logic trip_in,
   output logic      ready,
   output logic      tripped
);
   int   wait_reg;
   logic kept_reg = 1'b0;
   // Kept bit ignores reset so a trip outlives power loss
   always @(posedge clk)
   begin
      if (store)
         kept_reg <= trip_in;
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         wait_reg <= 0;
      else if (wait_reg < READY_DELAY)
         wait_reg <= wait_reg + 1;
   end
   assign ready = (wait_reg == READY_DELAY);
   // Data is not valid before ready, so show the inverse there
   assign tripped = ready ? kept_reg : ~kept_reg;
endmodule : nv_store_model

// ===== verif/lift_safety_contact_monitor_tb.sv
// Purpose: Self-checking bench for the lift safety contact monitor
// Assumes: Shortened counts: standstill 50, press and gap 20 cycles
// Notes:   Nominal speed 1000 mm/s gives a trip above 1150 mm/s
`timescale 1ns/1ps
module lift_safety_contact_monitor_tb;
   import lift_safety_pkg::*;
   localparam int STILL = 50;
   logic               clk = 1'b0;
   logic               rst = 1'b1;
   car_state_t         car = '0;
   mode_t              mode = MODE_NORMAL;
   logic [SPEED_W-1:0] nominal = 16'h03e8;
   zone_cfg_t          zone = {16'h00c8, 16'h008c};
   logic               flush_wr = 1'b0;
   logic [3:0]         flush_idx = 4'h0;
   logic [POS_W-1:0]   flush_pos = '0;
   logic [15:0]        lev_en = 16'h0000;
   logic [15:0]        rel_en = 16'h0000;
   logic               doors = 1'b1;
   logic               dir = 1'b0;
   logic               button = 1'b0;
   logic               nv_ready, nv_tripped, nv_store, nv_out;
   logic               c1, c2, cg, latched, teach, bridging;
   int                 fails = 0;
   int                 tests_run = 0;
   always #25 clk = ~clk;
   lift_safety_contact_monitor #(.NUM_FLOORS(16), .STANDSTILL_CYCLES(STILL),
      .PRESS_MAX_CYCLES(20), .GAP_MAX_CYCLES(20)) dut (
      .CLK(clk), .RST(rst), .CAR(car), .MODE(mode), .NOMINAL_SPEED(nominal),
      .ZONE_CFG(zone), .FLUSH_WR(flush_wr), .FLUSH_IDX(flush_idx), .FLUSH_POS(flush_pos),
      .LEVEL_BRIDGE_EN(lev_en), .RELEVEL_BRIDGE_EN(rel_en), .DOORS_CLOSED(doors),
      .DIRECTION_PRESSED(dir), .RESET_BUTTON(button), .NV_READY(nv_ready),
      .NV_TRIPPED(nv_tripped), .NV_STORE(nv_store), .NV_TRIPPED_OUT(nv_out),
      .FIRST_ACTUATOR_CONTACT(c1), .SECOND_ACTUATOR_CONTACT(c2),
      .SAFETY_GEAR_ACTUATOR_CONTACT(cg), .OVERSPEED_LATCHED(latched),
      .TEACH_TRIP(teach), .BRIDGING_ACTIVE(bridging));
   nv_store_model #(.READY_DELAY(4)) nv (.clk(clk), .rst(rst), .store(nv_store),
      .trip_in(nv_out), .ready(nv_ready), .tripped(nv_tripped));
   // ------------------------------
   // Shared tasks
   // ------------------------------
   task summarize;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   task check(input logic seen, input logic exp, input string what);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask : check
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task power_up;
      @(posedge clk);
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int n = 0; n < 50 && nv_ready !== 1'b1; n++)
         @(posedge clk);
      if (nv_ready !== 1'b1)
      begin
         fails++;
         summarize();
      end
      cyc(3);
   endtask : power_up
   task drive(input mode_t m, input logic [SPEED_W-1:0] s, input logic d);
      @(posedge clk);
      mode <= m;
      car.speed <= s;
      dir <= d;
      cyc(2);
   endtask : drive
   task press(input int h, input int l);
      @(posedge clk);
      button <= 1'b1;
      repeat (h) @(posedge clk);
      button <= 1'b0;
      cyc(l);
   endtask : press
   task door(input logic [POS_W-1:0] p, input logic [15:0] s, input logic [1:0] en,
             input logic d, input logic exp);
      @(posedge clk);
      car <= {p, s};
      lev_en <= {12'h000, en[1], 3'h0};
      rel_en <= {12'h000, en[0], 3'h0};
      doors <= d;
      cyc(2);
      check(c2, exp, "second contact in door case");
   endtask : door
   // ------------------------------
   // Scenarios
   // ------------------------------
   task s_restore;
      power_up();
      check(latched | nv_out, 1'b0, "empty store left latch set");
      check(cg, 1'b1, "gear contact open after restore");
   endtask : s_restore
   task s_bridge;
      @(posedge clk);
      flush_wr <= 1'b1;
      flush_idx <= 4'h3;
      flush_pos <= 24'h002710;
      @(posedge clk);
      flush_wr <= 1'b0;
      door(24'h0027d8, 16'h031f, 2'b10, 1'b0, 1'b1);
      door(24'h0027d9, 16'h0000, 2'b10, 1'b0, 1'b0);
      door(24'h002648, 16'h031f, 2'b10, 1'b0, 1'b1);
      door(24'h002710, 16'h0320, 2'b10, 1'b0, 1'b0);
      door(24'h002710, 16'h0000, 2'b00, 1'b0, 1'b0);
      door(24'h002684, 16'h012b, 2'b01, 1'b0, 1'b1);
      door(24'h002683, 16'h0000, 2'b01, 1'b0, 1'b0);
      door(24'h002710, 16'h012c, 2'b01, 1'b0, 1'b0);
      door(24'h002710, 16'h0000, 2'b00, 1'b1, 1'b1);
   endtask : s_bridge
   task s_teach;
      drive(MODE_TEACH, 16'h0276, 1'b0);
      check(c1, 1'b1, "teach trip at limit speed");
      drive(MODE_TEACH, 16'h0277, 1'b0);
      check(c1, 1'b0, "no teach trip above limit");
      drive(MODE_TEACH, 16'h0000, 1'b0);
      cyc(STILL - 6);
      check(c1, 1'b0, "teach trip cleared early");
      cyc(10);
      check(c1, 1'b1, "teach trip not cleared");
      drive(MODE_NORMAL, 16'h0000, 1'b0);
   endtask : s_teach
   task s_inspect;
      drive(MODE_INSPECTION, 16'h0000, 1'b0);
      check(c1 | c2, 1'b0, "inspection hold not open");
      drive(MODE_INSPECTION, 16'h0000, 1'b1);
      check(c1 & c2, 1'b1, "direction did not close");
      drive(MODE_INSPECTION, 16'h0000, 1'b0);
      drive(MODE_NORMAL, 16'h0000, 1'b0);
      check(c1 & c2, 1'b1, "leaving inspection did not close");
   endtask : s_inspect
   task s_overspeed;
      drive(MODE_NORMAL, 16'h047e, 1'b0);
      check(cg, 1'b1, "trip at final speed itself");
      drive(MODE_NORMAL, 16'h047f, 1'b0);
      check(c1 | c2 | cg, 1'b0, "over-speed left a contact closed");
      drive(MODE_INSPECTION, 16'h0000, 1'b1);
      drive(MODE_NORMAL, 16'h0000, 1'b0);
      cyc(STILL + 10);
      check(latched, 1'b1, "latch released by standstill");
      power_up();
      check(cg | c1, 1'b0, "trip lost over power cycle");
      press(20, 10);
      press(10, 10);
      press(10, 10);
      check(latched, 1'b1, "long press accepted");
      cyc(25);
      press(10, 10);
      press(10, 19);
      press(10, 10);
      check(latched, 1'b1, "long gap accepted");
      cyc(25);
      press(19, 18);
      press(10, 10);
      press(10, 10);
      check(latched, 1'b0, "valid reset not taken");
      check(c1 & c2 & cg, 1'b1, "contacts stay open after reset");
   endtask : s_overspeed
   initial
   begin
      s_restore();
      s_bridge();
      s_teach();
      s_inspect();
      s_overspeed();
      summarize();
   end
endmodule : lift_safety_contact_monitor_tb
bind lift_safety_contact_monitor lift_safety_monitor #(.STANDSTILL_CYCLES(STANDSTILL_CYCLES)) mon (
   .CLK(CLK), .RST(RST), .CAR(CAR), .MODE(MODE), .NOMINAL_SPEED(NOMINAL_SPEED),
   .DOORS_CLOSED(DOORS_CLOSED), .DIRECTION_PRESSED(DIRECTION_PRESSED),
   .RESET_BUTTON(RESET_BUTTON), .NV_READY(NV_READY), .NV_STORE(NV_STORE),
   .FIRST_ACTUATOR_CONTACT(FIRST_ACTUATOR_CONTACT),
   .SECOND_ACTUATOR_CONTACT(SECOND_ACTUATOR_CONTACT),
   .SAFETY_GEAR_ACTUATOR_CONTACT(SAFETY_GEAR_ACTUATOR_CONTACT),
   .OVERSPEED_LATCHED(OVERSPEED_LATCHED), .TEACH_TRIP(TEACH_TRIP),
   .BRIDGING_ACTIVE(BRIDGING_ACTIVE));
